// ---- hw/fspc_top.sv ----
// Flash self-program controller with APB register access.
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/100ps
`include "fspc_consts.svh"
module fspc_top #(
	parameter int PROG_CYCLES = `FSPC_PROG_CYC
) (
	input  wire logic        clock,
	input  wire logic        reset,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [13:0] flash_rdata,
	output logic      [9:0]  flash_addr,
	output logic             flash_rd,
	output logic             flash_cfg,
	output logic             flash_erase,
	output logic             flash_prog,
	output logic      [223:0] flash_wdata,
	output logic             core_nop,
	output logic             core_stall
);
	// *********************************************************
	// Register state
	// *********************************************************
	logic [7:0]  addr_lo_q, addr_lo_d;
	logic [0:0]  addr_hi_q, addr_hi_d;
	logic [13:0] data_q, data_d;
	logic        rd_q, rd_d, wr_q, wr_d, write_enable_bit_q, write_enable_bit_d, write_error_flag_q, write_error_flag_d;
	logic        erase_q, erase_d, latch_load_only_q, latch_load_only_d, config_space_select_q, config_space_select_d;
	logic [1:0]  key_q, key_d;
	logic        busy_mark_q, busy_mark_d;
	fspc_pkg::fspc_state_t st_q, st_d;
	logic [2:0]  cnt_q, cnt_d;
	logic [31:0] tmr_q, tmr_d;
	logic [31:0] prdata_q, prdata_d;
	logic        pready_q, pready_d;
	logic        fe_q, fp_q, fr_q, nop_q, stall_q;
	logic        fe_d, fp_d, fr_d, nop_d, stall_d;
	logic        lat_load, lat_blank;
	logic        acc, wr_acc, rd_acc, start_wr, unlocked;
	logic [13:0] lat_word;

	// An APB access completes one cycle after setup, pready pulses.
	assign acc    = psel && penable && pready_q;
	assign wr_acc = acc && pwrite;
	assign rd_acc = acc && !pwrite;
	assign unlocked = key_q == 2'h2;
	assign start_wr = wr_acc && paddr == `FSPC_CONTROL &&
		pwdata[`FSPC_B_WR] && !wr_q && st_q == fspc_pkg::FSPC_IDLE;

	// *********************************************************
	// Register and sequencer next state
	// *********************************************************
	always_comb begin
		addr_lo_d = addr_lo_q;
		addr_hi_d = addr_hi_q;
		data_d = data_q;
		rd_d = rd_q;
		wr_d = wr_q;
		write_enable_bit_d = write_enable_bit_q;
		write_error_flag_d = write_error_flag_q;
		erase_d = erase_q;
		latch_load_only_d = latch_load_only_q;
		config_space_select_d = config_space_select_q;
		key_d = key_q;
		busy_mark_d = busy_mark_q;
		st_d = st_q;
		cnt_d = cnt_q;
		tmr_d = tmr_q;
		fe_d = 1'b0;
		fp_d = 1'b0;
		fr_d = 1'b0;
		nop_d = 1'b0;
		stall_d = stall_q;
		lat_load = 1'b0;
		lat_blank = 1'b0;
		pready_d = psel && !penable;
		prdata_d = 32'h00000000;
		// Any other write to the key register breaks the pair.
		if (wr_acc && paddr == `FSPC_UNLOCK_KEY) begin
			if (pwdata[7:0] == `FSPC_KEY1)
				key_d = 2'h1;
			else if (pwdata[7:0] == `FSPC_KEY2 && key_q == 2'h1)
				key_d = 2'h2;
			else
				key_d = 2'h0;
		end else if (wr_acc) begin
			key_d = 2'h0;
		end
		if (wr_acc) begin
			unique case (paddr)
				`FSPC_ADDR_LOW:  addr_lo_d = pwdata[7:0];
				`FSPC_ADDR_HIGH: addr_hi_d = pwdata[0:0];
				`FSPC_DATA_LOW:  data_d[7:0] = pwdata[7:0];
				`FSPC_DATA_HIGH: data_d[13:8] = pwdata[5:0];
				`FSPC_CONTROL: begin
					// Triggers are set-only; software cannot abort.
					rd_d = rd_q | pwdata[`FSPC_B_RD];
					write_enable_bit_d = pwdata[`FSPC_B_WRITE_ENABLE_BIT];
					write_error_flag_d = pwdata[`FSPC_B_WRITE_ERROR_FLAG];
					erase_d = pwdata[`FSPC_B_ERASE];
					latch_load_only_d = pwdata[`FSPC_B_LATCH_LOAD_ONLY];
					config_space_select_d = pwdata[`FSPC_B_CONFIG_SPACE_SELECT];
				end
				default: ;
			endcase
		end
		// Read data is taken in the setup cycle so it stands at ready.
		if (psel && !penable && !pwrite) begin
			unique case (paddr)
				`FSPC_ADDR_LOW:  prdata_d = {24'h000000, addr_lo_q};
				`FSPC_ADDR_HIGH: prdata_d = {31'h00000000, addr_hi_q};
				`FSPC_DATA_LOW:  prdata_d = {24'h000000, data_q[7:0]};
				`FSPC_DATA_HIGH: prdata_d = {26'h0000000, data_q[13:8]};
				`FSPC_CONTROL:   prdata_d = {25'h0000000, config_space_select_q, latch_load_only_q,
					erase_q, write_error_flag_q, write_enable_bit_q, wr_q, rd_q};
				`FSPC_UNLOCK_KEY: prdata_d = 32'h00000000;
				default: prdata_d = 32'h00000000;
			endcase
		end
		// Write trigger only acts with write-enable and the key pair.
		if (start_wr && write_enable_bit_q && unlocked) begin
			wr_d = 1'b1;
			st_d = fspc_pkg::FSPC_NOPS;
			cnt_d = `FSPC_NOP_CYC;
			nop_d = 1'b1;
			busy_mark_d = erase_q || !latch_load_only_q;
			// The last word joins its latch as the row program starts.
			if (erase_q) begin
				fe_d = 1'b1;
			end else begin
				lat_load = 1'b1;
				fp_d = !latch_load_only_q;
			end
		end
		unique case (st_q)
			fspc_pkg::FSPC_IDLE: begin
				if (rd_q || (wr_acc && paddr == `FSPC_CONTROL &&
					pwdata[`FSPC_B_RD])) begin
					// The cycle after the two forced no-ops goes to the flash fetch.
					if (st_d == fspc_pkg::FSPC_IDLE) begin
						st_d = fspc_pkg::FSPC_READ;
						cnt_d = `FSPC_READ_CYC;
						nop_d = 1'b1;
					end
				end
			end
			fspc_pkg::FSPC_READ: begin
				nop_d = 1'b1;
				cnt_d = cnt_q - 3'h1;
				if (cnt_q == 3'h1) begin
					fr_d = 1'b1;
					nop_d = 1'b0;
				end
				if (cnt_q == 3'h0) begin
					nop_d = 1'b0;
					data_d = flash_rdata;
					rd_d = 1'b0;
					st_d = fspc_pkg::FSPC_IDLE;
				end
			end
			fspc_pkg::FSPC_NOPS: begin
				cnt_d = cnt_q - 3'h1;
				nop_d = cnt_q != 3'h1;
				if (cnt_q == 3'h1) begin
					if (busy_mark_q) begin
						st_d = fspc_pkg::FSPC_BUSY;
						tmr_d = PROG_CYCLES;
						stall_d = 1'b1;
					end else begin
						wr_d = 1'b0;
						st_d = fspc_pkg::FSPC_IDLE;
					end
				end
			end
			fspc_pkg::FSPC_BUSY: begin
				tmr_d = tmr_q - 32'h1;
				if (tmr_q == 32'h1) begin
					stall_d = 1'b0;
					wr_d = 1'b0;
					lat_blank = 1'b1;
					st_d = fspc_pkg::FSPC_IDLE;
				end
			end
			default: st_d = fspc_pkg::FSPC_IDLE;
		endcase
	end

	// Reset sets the error mark when it cuts a write short in the busy state.
	always_ff @(posedge clock) begin
		if (reset) begin
			write_error_flag_q <= (st_q == fspc_pkg::FSPC_BUSY) | write_error_flag_q;
			addr_lo_q <= 8'h00;
			addr_hi_q <= 1'b0;
			data_q <= 14'h0000;
			rd_q <= 1'b0;
			wr_q <= 1'b0;
			write_enable_bit_q <= 1'b0;
			erase_q <= 1'b0;
			latch_load_only_q <= 1'b0;
			config_space_select_q <= 1'b0;
			key_q <= 2'h0;
			busy_mark_q <= 1'b0;
			st_q <= fspc_pkg::FSPC_IDLE;
			cnt_q <= 3'h0;
			tmr_q <= 32'h0;
			prdata_q <= 32'h00000000;
			pready_q <= 1'b0;
			fe_q <= 1'b0;
			fp_q <= 1'b0;
			fr_q <= 1'b0;
			nop_q <= 1'b0;
			stall_q <= 1'b0;
		end else begin
			write_error_flag_q <= write_error_flag_d;
			addr_lo_q <= addr_lo_d;
			addr_hi_q <= addr_hi_d;
			data_q <= data_d;
			rd_q <= rd_d;
			wr_q <= wr_d;
			write_enable_bit_q <= write_enable_bit_d;
			erase_q <= erase_d;
			latch_load_only_q <= latch_load_only_d;
			config_space_select_q <= config_space_select_d;
			key_q <= key_d;
			busy_mark_q <= busy_mark_d;
			st_q <= st_d;
			cnt_q <= cnt_d;
			tmr_q <= tmr_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			fe_q <= fe_d;
			fp_q <= fp_d;
			fr_q <= fr_d;
			nop_q <= nop_d;
			stall_q <= stall_d;
		end
	end

	assign lat_word = data_q;

	// Latch bank; its outputs are flip-flops inside the bank.
	fspc_latches u_lat (
		.clock (clock),
		.reset (reset),
		.load  (lat_load),
		.index (addr_lo_q[`FSPC_LAT_BITS-1:0]),
		.word  (lat_word),
		.blank (lat_blank),
		.row   (flash_wdata)
	);

	assign prdata      = prdata_q;
	assign pready      = pready_q;
	assign pslverr     = 1'b0;
	assign flash_addr  = {config_space_select_q, addr_hi_q, addr_lo_q};
	assign flash_rd    = fr_q;
	assign flash_cfg   = config_space_select_q;
	assign flash_erase = fe_q;
	assign flash_prog  = fp_q;
	assign core_nop    = nop_q;
	assign core_stall  = stall_q;

	// *********************************************************
	// Checks
	// *********************************************************
	// Stall rises after one idle cycle behind the start pulse.
	sequence s_stall_gap;
		!stall_q ##1 stall_q;
	endsequence

	// Flash fetch pulse, then the read trigger drops.
	sequence s_read_fetch;
		fr_q ##1 !rd_q;
	endsequence

	a_stall_follows: assert property (
		@(posedge clock) disable iff (reset)
		(fe_q || fp_q) |=> s_stall_gap)
		else $error("stall did not follow start");
	a_load_nostall: assert property (
		@(posedge clock) disable iff (reset)
		lat_load && latch_load_only_q |=> (!stall_q) [*4])
		else $error("latch load stalled");
	a_nops_forced: assert property (
		@(posedge clock) disable iff (reset)
		$rose(wr_q) |-> nop_q)
		else $error("no forced no-op after trigger");
	a_wr_locked: assert property (
		@(posedge clock) disable iff (reset)
		$rose(wr_q) |-> $past(write_enable_bit_q) && $past(key_q) == 2'h2)
		else $error("write started without unlock");
	a_key_zero: assert property (
		@(posedge clock) disable iff (reset)
		rd_acc && paddr == `FSPC_UNLOCK_KEY |-> prdata == 32'h00000000)
		else $error("unlock register read not zero");
	a_read_done: assert property (
		@(posedge clock) disable iff (reset)
		$rose(rd_q) |-> ##[1:4] s_read_fetch)
		else $error("read did not complete");
	a_wr_setonly: assert property (
		@(posedge clock) disable iff (reset)
		wr_acc && paddr == `FSPC_CONTROL && wr_q &&
		st_q == fspc_pkg::FSPC_BUSY && tmr_q != 32'h1 |=> wr_q)
		else $error("write trigger cleared by software");
	a_blank_end: assert property (
		@(posedge clock) disable iff (reset)
		lat_blank |=> flash_wdata[13:0] == `FSPC_BLANK)
		else $error("latches not blank after operation");
endmodule // fspc_top

// ---- include/fspc_consts.svh ----
// Constants for the flash self-program controller.
`ifndef FSPC_CONSTS_SVH
`define FSPC_CONSTS_SVH
// APB byte offsets.
`define FSPC_ADDR_LOW    8'h00
`define FSPC_ADDR_HIGH   8'h04
`define FSPC_DATA_LOW    8'h08
`define FSPC_DATA_HIGH   8'h0C
`define FSPC_CONTROL     8'h10
`define FSPC_UNLOCK_KEY  8'h14
// Control register bit positions.
`define FSPC_B_RD        0
`define FSPC_B_WR        1
`define FSPC_B_WRITE_ENABLE_BIT      2
`define FSPC_B_WRITE_ERROR_FLAG     3
`define FSPC_B_ERASE     4
`define FSPC_B_LATCH_LOAD_ONLY      5
`define FSPC_B_CONFIG_SPACE_SELECT      6
// Unlock keys and blank word.
`define FSPC_KEY1        8'h55
`define FSPC_KEY2        8'hAA
`define FSPC_BLANK       14'h3FFF
// Rows of 16 words (larger variant), 4-bit latch index.
`define FSPC_ROW_WORDS   16
`define FSPC_LAT_BITS    4
// Core cycles: read ignores two slots, forced no-ops are two.
`define FSPC_READ_CYC    3'h2
`define FSPC_NOP_CYC     3'h2
// Program/erase time in microseconds and its count at 40 MHz.
`define FSPC_PROG_US     2000
`define FSPC_CLK_MHZ     40
`define FSPC_PROG_CYC    (`FSPC_PROG_US * `FSPC_CLK_MHZ)
`endif

// ---- include/fspc_pkg.sv ----
// Types for the flash self-program controller.
package fspc_pkg;
	// Idle to forced no-ops to busy step one bit at a time; busy back to idle flips two.
	typedef enum logic [2:0] {
		FSPC_IDLE  = 3'h0,
		FSPC_READ  = 3'h4,
		FSPC_NOPS  = 3'h1,
		FSPC_BUSY  = 3'h3
	} fspc_state_t;
endpackage

// ---- hw/fspc_latches.sv ----
// Write latch bank of one flash row.
`timescale 1ns/100ps
`include "fspc_consts.svh"
module fspc_latches (
	input  wire logic                       clock,
	input  wire logic                       reset,
	input  wire logic                       load,
	input  wire logic [`FSPC_LAT_BITS-1:0]  index,
	input  wire logic [13:0]                word,
	input  wire logic                       blank,
	output logic      [14*`FSPC_ROW_WORDS-1:0] row
);
	logic [13:0] lat_q [`FSPC_ROW_WORDS];
	logic [13:0] lat_d [`FSPC_ROW_WORDS];

	// Each latch loads alone or returns to blank after an operation.
	genvar g;
	generate
		for (g = 0; g < `FSPC_ROW_WORDS; g++) begin : g_lat
			always_comb begin
				lat_d[g] = lat_q[g];
				if (blank)
					lat_d[g] = `FSPC_BLANK;
				else if (load && int'(index) == g)
					lat_d[g] = word;
			end
			always_ff @(posedge clock) begin
				if (reset)
					lat_q[g] <= `FSPC_BLANK;
				else
					lat_q[g] <= lat_d[g];
			end
			assign row[14*g +: 14] = lat_q[g];
		end
	endgenerate
endmodule // fspc_latches

// ---- dv/fspc_flash_model.sv ----
// Behavioural flash array on the far side of the controller.
`timescale 1ns/100ps
module fspc_flash_model (
	input  wire logic         clock,
	input  wire logic [9:0]   flash_addr,
	input  wire logic         flash_erase,
	input  wire logic         flash_prog,
	input  wire logic [223:0] flash_wdata,
	output logic      [13:0]  flash_rdata
);
	logic [13:0] mem [1024];

	// A pattern the bench recomputes on its own side.
	initial begin
		for (int i = 0; i < 1024; i++) begin
			mem[i] = 14'(i * 37 + 5);
		end
	end

	// Reads are combinational, so any sampling point sees the word.
	assign flash_rdata = mem[flash_addr];

	// Erase blanks a whole row; programming can only clear bits.
	always @(posedge clock) begin
		for (int i = 0; i < 16; i++) begin
			if (flash_erase === 1'b1) begin
				mem[{flash_addr[9:4], 4'(i)}] = 14'h3FFF;
			end
			if (flash_prog === 1'b1) begin
				mem[{flash_addr[9:4], 4'(i)}] &= flash_wdata[14*i+:14];
			end
		end
	end
endmodule // fspc_flash_model

// ---- dv/testbench.sv ----
// Self-checking bench for the flash self-program controller.
`timescale 1ns/100ps
`include "fspc_consts.svh"
module testbench;
	localparam int PROG = 20;
	logic         clock, reset, psel, penable, pwrite;
	logic [7:0]   paddr;
	logic [31:0]  pwdata, prdata, r;
	logic         pready, pslverr, flash_rd, flash_cfg, flash_erase;
	logic         flash_prog, core_nop, core_stall;
	logic [13:0]  flash_rdata;
	logic [9:0]   flash_addr;
	logic [223:0] flash_wdata;
	int           n_errors, comparisons, a, d, s, b, p;
	int           n_nop = 0, n_stall = 0, n_prog = 0, n_erase = 0;
	int           n_rd = 0;
	int           ref_mem [1024];
	int           lat [16];

	fspc_top #(.PROG_CYCLES(PROG)) i_fspc_top (.clock(clock), .reset(reset),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .flash_rdata(flash_rdata),
		.flash_addr(flash_addr), .flash_rd(flash_rd), .flash_cfg(flash_cfg),
		.flash_erase(flash_erase), .flash_prog(flash_prog),
		.flash_wdata(flash_wdata), .core_nop(core_nop),
		.core_stall(core_stall));
	fspc_flash_model i_fspc_flash_model (.clock(clock),
		.flash_addr(flash_addr), .flash_erase(flash_erase),
		.flash_prog(flash_prog), .flash_wdata(flash_wdata),
		.flash_rdata(flash_rdata));

	// Free-running core clock.
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	// Count core-side cycles; deltas give exact no-op and stall lengths.
	always @(posedge clock) begin
		n_nop <= n_nop + int'(core_nop === 1'b1);
		n_stall <= n_stall + int'(core_stall === 1'b1);
		n_prog <= n_prog + int'(flash_prog === 1'b1);
		n_erase <= n_erase + int'(flash_erase === 1'b1);
		n_rd <= n_rd + int'(flash_rd === 1'b1);
	end

	// ****************************************
	// Checking and bus tasks
	// ****************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("errors=%0d comparisons=%0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// One APB transfer; read data lands in r at the ready edge.
	task automatic apb(input logic w, input logic [7:0] ad,
		input logic [31:0] dt);
		int i;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= dt;
		@(posedge clock);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge clock);
			i++;
		end while (pready !== 1'b1 && i < 50);
		if (i >= 50) begin
			n_errors++;
			print_verdict();
		end
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Poll until both triggers are back to zero, bounded.
	task automatic wait_done();
		for (int i = 0; i < 60; i++) begin
			apb(1'b0, `FSPC_CONTROL, 32'h0);
			if (r[1:0] === 2'h0) return;
		end
		n_errors++;
		print_verdict();
	endtask

	task automatic set_word(input int ad, input int dt);
		apb(1'b1, `FSPC_ADDR_LOW, 32'(ad & 255));
		apb(1'b1, `FSPC_ADDR_HIGH, 32'(ad >> 8));
		apb(1'b1, `FSPC_DATA_LOW, 32'(dt & 255));
		apb(1'b1, `FSPC_DATA_HIGH, 32'(dt >> 8));
	endtask

	// Control bits first, since write-enable must stand before the
	// trigger; then the unlock pair and the write trigger.
	task automatic op(input logic [7:0] c, input bit wt);
		apb(1'b1, `FSPC_CONTROL, {24'h0, c});
		apb(1'b1, `FSPC_UNLOCK_KEY, {24'h0, `FSPC_KEY1});
		apb(1'b1, `FSPC_UNLOCK_KEY, {24'h0, `FSPC_KEY2});
		apb(1'b1, `FSPC_CONTROL, {24'h0, c | 8'h02});
		if (wt) wait_done();
	endtask

	// Word read with the config select taken from address bit 9, against the model.
	// Addresses from 512 up select the configuration region.
	task automatic read_word(input int ad);
		int q, m;
		set_word(ad, 0);
		q = n_rd;
		m = n_nop;
		apb(1'b1, `FSPC_CONTROL, 32'h1 | 32'((ad >> 9) << 6));
		wait_done();
		chk(32'(n_rd - q), 32'h1);
		chk(32'(n_nop - m), 32'h2);
		chk(32'(flash_addr), 32'(ad));
		chk(32'(flash_cfg), 32'(ad >> 9));
		apb(1'b0, `FSPC_DATA_LOW, 32'h0);
		chk(r, 32'(ref_mem[ad] & 255));
		apb(1'b0, `FSPC_DATA_HIGH, 32'h0);
		chk(r, 32'(ref_mem[ad] >> 8));
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		reset = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		n_errors = 0;
		comparisons = 0;
		s = $urandom(50047);
		for (int i = 0; i < 1024; i++) begin
			ref_mem[i] = (i * 37 + 5) & 16'h3FFF;
		end
		for (int i = 0; i < 16; i++) begin
			lat[i] = 16'h3FFF;
		end
		repeat (16) @(posedge clock);
		reset <= 1'b0;
		apb(1'b0, `FSPC_CONTROL, 32'h0);
		chk(r, 32'h0);
		apb(1'b0, `FSPC_UNLOCK_KEY, 32'h0);
		chk(r, 32'h0);
		for (int k = 0; k < 4; k++) begin
			d = k == 1 ? 512 : 0;
			read_word(k == 0 ? 511 : d + int'($urandom_range(511)));
		end
		// Refused writes: no enable, then a pair broken by another write.
		a = 16 * int'($urandom_range(31));
		set_word(a, 16'h2A5C);
		apb(1'b0, `FSPC_DATA_LOW, 32'h0);
		chk(r, 32'h5C);
		s = n_prog + n_erase;
		op(8'h00, 1'b1);
		apb(1'b1, `FSPC_CONTROL, 32'h4);
		apb(1'b1, `FSPC_UNLOCK_KEY, {24'h0, `FSPC_KEY1});
		apb(1'b1, `FSPC_DATA_LOW, 32'h0);
		apb(1'b1, `FSPC_UNLOCK_KEY, {24'h0, `FSPC_KEY2});
		apb(1'b1, `FSPC_CONTROL, 32'h6);
		wait_done();
		chk(n_prog + n_erase, s);
		// Three latch loads, then the last word programs the row.
		p = n_prog;
		for (int k = 0; k < 4; k++) begin
			d = int'($urandom_range(16383));
			set_word(a + k * 3, d);
			lat[k * 3] = d;
			s = n_nop;
			b = n_stall;
			op(k < 3 ? 8'h24 : 8'h04, 1'b1);
			chk(n_nop - s, 2);
			chk(n_stall - b, k < 3 ? 0 : PROG);
		end
		chk(n_prog - p, 1);
		for (int i = 0; i < 16; i++) begin
			ref_mem[a + i] &= lat[i];
			lat[i] = 16'h3FFF;
		end
		for (int k = 0; k < 16; k += 3) begin
			read_word(a + k);
		end
		// Erase the row from a mid-row address.
		p = n_erase;
		set_word(a + 7, 0);
		op(8'h14, 1'b1);
		chk(n_erase - p, 1);
		for (int i = 0; i < 16; i++) begin
			ref_mem[a + i] = 16'h3FFF;
		end
		read_word(a + 15);
		// Reset while the core is stalled must leave the error flag.
		op(8'h04, 1'b0);
		for (int i = 0; i < 40 && core_stall !== 1'b1; i++) @(posedge clock);
		// A control write with the trigger bit low must not abort.
		apb(1'b1, `FSPC_CONTROL, 32'h4);
		apb(1'b0, `FSPC_CONTROL, 32'h0);
		chk(r & 32'h02, 32'h02);
		reset <= 1'b1;
		@(posedge clock);
		reset <= 1'b0;
		apb(1'b0, `FSPC_CONTROL, 32'h0);
		chk(r & 32'h0C, 32'h08);
		print_verdict();
	end
endmodule // testbench
